// ===== hw/strap_sample_boot_select.v
// strap capture, boot decode and wishbone status registers
// Functional notes
// - each strap pin level is caught as a 0 or 1 bit during system reset.
// - caught strap bits hold until the next system reset, whatever the pins do later.
// - every system reset source (power-on, watchdogs, brownout, glitch) samples.
// - pin_c=1,pin_a=1 selects flash boot; pin_c=0,a=1,b=1 selects download.
// - print enable follows the print fuse: on, on if b low, on if b high, off.
// - debug from usb if fuse is 0, else pin_d=0 selects pins, 1 selects usb.
// - latched pin_a, pin_b and pin_d are readable in the strap status register.
// - after reset the strap pins are released to normal use.
// - pin_c has its internal pull-up on while strapping.
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "strap_sample_defines.vh"

module strap_sample_boot_select #(
   parameter CHIP_EN_LOW_CYCLES = `CHIP_EN_LOW_CYCLES
) (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   input  wire        clk_en,
   // reset sources
   input  wire        chip_enable_in,
   input  wire        slow_wdt_reset,
   input  wire        brownout_reset,
   input  wire        super_wdt_reset,
   input  wire        xtal_glitch_reset,
   // strap pins
   input  wire        strap_pin_a,
   input  wire        strap_pin_b,
   input  wire        strap_pin_c,
   input  wire        strap_pin_d,
   output reg         strap_pin_c_pullup,
   output reg         strap_duty,
   // decoded outputs
   output reg         flash_boot,
   output reg         download_boot,
   output reg         invalid_strap,
   output reg         print_enable,
   output reg         debug_from_usb,
   output reg         system_reset_out,
   // wishbone slave
   input  wire [7:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_we_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         wb_err_o
);

   reg  [15:0] en_low_cnt_q;
   reg         por_armed_q;
   reg         sys_reset_q;
   reg  [3:0]  strap_q;   // d c b a
   reg  [1:0]  print_fuse_q;
   reg         debug_fuse_q;
   wire        chip_en_reset;
   wire        any_reset;
   reg         flash_d;
   reg         download_d;
   reg         invalid_d;
   reg         print_d;
   reg         debug_usb_d;
   reg  [31:0] rd_d;
   reg         hit_d;

   // chip enable counts as a reset only after a long enough low time;
   // shorter dips are glitches and are not trusted to restart the chip
   assign chip_en_reset = (en_low_cnt_q >= CHIP_EN_LOW_CYCLES[15:0]);
   assign any_reset = chip_en_reset | slow_wdt_reset | brownout_reset |
                      super_wdt_reset | xtal_glitch_reset;

   always @(posedge clk) begin
      if (reset) begin
         en_low_cnt_q <= 16'h0000;
         por_armed_q  <= 1'b1;
         sys_reset_q  <= 1'b1;
      end else if (clk_en) begin
         if (chip_enable_in)
            en_low_cnt_q <= 16'h0000;
         else if (!chip_en_reset)
            en_low_cnt_q <= en_low_cnt_q + 16'h0001;
         por_armed_q <= 1'b0;
         sys_reset_q <= any_reset | por_armed_q;
      end
   end

   // sample while in system reset, freeze once out of it
   always @(posedge clk) begin
      if (reset) begin
         strap_q <= 4'h0;
      end else if (clk_en && (any_reset || por_armed_q)) begin
         strap_q <= {strap_pin_d, strap_pin_c, strap_pin_b,
                     strap_pin_a};
      end
   end

   always @* begin
      flash_d    = 1'b0;
      download_d = 1'b0;
      invalid_d  = ~strap_q[1] & ~strap_q[2];
      if (!invalid_d) begin
         flash_d    = strap_q[2] & strap_q[0];
         download_d = ~strap_q[2] & strap_q[0] & strap_q[1];
      end
      case (print_fuse_q)
         `PRINT_ALWAYS_ON:  print_d = 1'b1;
         `PRINT_WHEN_B_LOW: print_d = ~strap_q[1];
         `PRINT_WHEN_B_HIGH: print_d = strap_q[1];
         default:           print_d = 1'b0;
      endcase
      debug_usb_d = ~debug_fuse_q | strap_q[3];
   end

   always @(posedge clk) begin
      if (reset) begin
         flash_boot         <= 1'b0;
         download_boot      <= 1'b0;
         invalid_strap      <= 1'b0;
         print_enable       <= 1'b0;
         debug_from_usb     <= 1'b1;
         system_reset_out   <= 1'b1;
         strap_duty         <= 1'b1;
         strap_pin_c_pullup <= 1'b1;
      end else if (clk_en) begin
         flash_boot       <= flash_d;
         download_boot    <= download_d;
         invalid_strap    <= invalid_d;
         print_enable     <= print_d;
         debug_from_usb   <= debug_usb_d;
         system_reset_out <= sys_reset_q;
         strap_duty       <= sys_reset_q;
         // pull-up only matters while the pin is strapping
         strap_pin_c_pullup <= sys_reset_q;
      end
   end

   // register read mux
   always @* begin
      rd_d  = 32'h0000_0000;
      hit_d = 1'b1;
      case (wb_adr_i)
         `STRAP_STATUS_OFFSET: begin
            rd_d[`STAT_PIN_A_BIT] = strap_q[0];
            rd_d[`STAT_PIN_B_BIT] = strap_q[1];
            rd_d[`STAT_PIN_D_BIT] = strap_q[3];
         end
         `BOOT_RESULT_OFFSET: begin
            rd_d[`RES_FLASH_BIT]     = flash_boot;
            rd_d[`RES_DOWNLOAD_BIT]  = download_boot;
            rd_d[`RES_INVALID_BIT]   = invalid_strap;
            rd_d[`RES_PRINT_BIT]     = print_enable;
            rd_d[`RES_DEBUG_USB_BIT] = debug_from_usb;
            rd_d[`RES_PIN_C_BIT]     = strap_q[2];
         end
         `FUSE_CTRL_OFFSET: begin
            rd_d[`FUSE_PRINT_MSB:`FUSE_PRINT_LSB] = print_fuse_q;
            rd_d[`FUSE_DEBUG_BIT] = debug_fuse_q;
         end
         default: hit_d = 1'b0;
      endcase
   end

   // single-cycle answer, ack drops the cycle after it is given
   always @(posedge clk) begin
      if (reset) begin
         wb_ack_o     <= 1'b0;
         wb_err_o     <= 1'b0;
         wb_dat_o     <= 32'h0000_0000;
         print_fuse_q <= `FUSE_PRINT_RESET;
         debug_fuse_q <= `FUSE_DEBUG_RESET;
      end else if (clk_en) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o) begin
            wb_ack_o <= hit_d;
            wb_err_o <= ~hit_d;
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_d;
            // fuses stand in as a writable register; status is read-only
            if (wb_we_i && wb_sel_i[0] &&
                wb_adr_i == `FUSE_CTRL_OFFSET) begin
               print_fuse_q <= wb_dat_i[`FUSE_PRINT_MSB:`FUSE_PRINT_LSB];
               debug_fuse_q <= wb_dat_i[`FUSE_DEBUG_BIT];
            end
         end
      end
   end

endmodule // strap_sample_boot_select

// ===== hw/strap_sample_defines.vh
// offsets, field positions, reset values and timing counts for the strap block
`ifndef STRAP_SAMPLE_DEFINES_VH
`define STRAP_SAMPLE_DEFINES_VH

// register byte offsets
`define STRAP_STATUS_OFFSET   8'h00
`define BOOT_RESULT_OFFSET    8'h04
`define FUSE_CTRL_OFFSET      8'h08
`define WB_ADDR_BITS          8

// strap status field positions
`define STAT_PIN_A_BIT        0
`define STAT_PIN_B_BIT        1
`define STAT_PIN_D_BIT        2

// boot result field positions
`define RES_FLASH_BIT         0
`define RES_DOWNLOAD_BIT      1
`define RES_INVALID_BIT       2
`define RES_PRINT_BIT         3
`define RES_DEBUG_USB_BIT     4
`define RES_PIN_C_BIT         5

// fuse control field positions and reset values
`define FUSE_PRINT_LSB        0
`define FUSE_PRINT_MSB        1
`define FUSE_DEBUG_BIT        2
`define FUSE_PRINT_RESET      2'h0
`define FUSE_DEBUG_RESET      1'h0

// print control fuse encodings
`define PRINT_ALWAYS_ON       2'h0
`define PRINT_WHEN_B_LOW      2'h1
`define PRINT_WHEN_B_HIGH     2'h2
`define PRINT_ALWAYS_OFF      2'h3

// chip enable low time in ns, clock period in ns
`define CHIP_EN_LOW_NS        50000
`define CLK_PERIOD_NS         25
`define CHIP_EN_LOW_CYCLES    (`CHIP_EN_LOW_NS / `CLK_PERIOD_NS)

`endif

// ===== verification/strap_host.sv
// host gpio model that drives or releases the four strap pins
`timescale 1ns/1ps
module strap_host (
   input  wire       clk,
   input  wire       drive,
   input  wire       keep,
   input  wire       pu_on,
   input  wire [3:0] want,
   output reg  [3:0] pins
);
   reg  tog_q;
   wire c_fix = want[2] | (keep & ~want[1]);
   initial begin
      tog_q = 1'b0;
      pins = 4'hf;
   end
   // released pins wander so a stale strap cannot pass unseen
   always @(posedge clk) begin
      tog_q <= ~tog_q;
      if (drive)
         pins <= {want[3], c_fix, want[1:0]};
      else
         pins <= {tog_q, pu_on | tog_q, ~tog_q, tog_q};
   end
endmodule // strap_host

// ===== verification/strap_props.sv
// assertions on strap capture and boot decode at the block's ports
`timescale 1ns/1ps
module strap_props #(parameter CHIP_EN_LOW_CYCLES = 8) (
   // clock, reset and reset sources
   input wire clk, reset, clk_en, chip_enable_in, slow_wdt_reset,
   input wire brownout_reset, super_wdt_reset, xtal_glitch_reset,
   // pins and decode
   input wire strap_pin_a, strap_pin_b, strap_pin_c, strap_pin_d,
   input wire strap_pin_c_pullup, strap_duty, flash_boot,
   input wire download_boot, invalid_strap, system_reset_out
);
   wire src = slow_wdt_reset | brownout_reset | super_wdt_reset |
      xtal_glitch_reset;
   wire [3:0] pins = {strap_pin_d, strap_pin_c, strap_pin_b, strap_pin_a};
   reg [15:0] low_q = 16'h0;
   always @(posedge clk) low_q <= chip_enable_in ? 16'h0 : low_q + 16'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // decode lags the sample by two edges, hence four stable cycles
   sequence held;
      (src && clk_en && $stable(pins)) [*4];
   endsequence
   sequence quiet;
      (!src && !system_reset_out && chip_enable_in) [*5];
   endsequence
   AST_INVALID: assert property (invalid_strap |-> !flash_boot &&
      !download_boot) else $error("invalid strap selects a boot mode");
   AST_FLASH: assert property (held |-> flash_boot ==
      (strap_pin_a & strap_pin_c)) else $error("flash boot decode wrong");
   AST_DOWNLOAD: assert property (held |-> download_boot ==
      (strap_pin_a & strap_pin_b & !strap_pin_c)) else $error("download bad");
   AST_SRC: assert property (src && clk_en |-> ##[1:3]
      system_reset_out) else $error("reset source not taken");
   AST_CHIPEN: assert property (low_q > CHIP_EN_LOW_CYCLES + 2 |->
      system_reset_out) else $error("long chip enable low not taken");
   AST_LATCHED: assert property (quiet |=> $stable({flash_boot,
      download_boot, invalid_strap})) else $error("latched decode moved");
   AST_PULLUP: assert property (system_reset_out |->
      strap_pin_c_pullup) else $error("pin c pull-up off in reset");
   AST_DUTY: assert property (quiet |-> !strap_duty)
      else $error("strap pins not released");
endmodule // strap_props

// ===== verification/test_strap_sample_boot_select.sv
// self-checking bench for strap capture, decode and status registers
`timescale 1ns/1ps
module test_strap_sample_boot_select;
   localparam int LOW = 8;
   logic clk = 0, reset = 1, chip_enable_in = 1, drive = 1, keep = 0;
   logic [3:0] src = 0, want = 0, pins;
   logic [7:0] wb_adr_i = 0;
   logic [31:0] wb_dat_i = 0, wb_dat_o;
   logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, wb_err_o, pu;
   logic [32:0] exp_q[$];
   int err_total = 0, n_tests = 0, cyc_n = 0;
   always #12.5 clk = ~clk;
   strap_sample_boot_select #(.CHIP_EN_LOW_CYCLES(LOW)) dut (
      .clk(clk), .reset(reset), .clk_en(1'b1),
      .chip_enable_in(chip_enable_in), .slow_wdt_reset(src[0]),
      .brownout_reset(src[1]), .super_wdt_reset(src[2]),
      .xtal_glitch_reset(src[3]), .strap_pin_a(pins[0]),
      .strap_pin_b(pins[1]), .strap_pin_c(pins[2]), .strap_pin_d(pins[3]),
      .strap_pin_c_pullup(pu), .strap_duty(), .flash_boot(),
      .download_boot(), .invalid_strap(), .print_enable(),
      .debug_from_usb(), .system_reset_out(), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
   strap_host host (.clk(clk), .drive(drive), .keep(keep), .pu_on(pu),
      .want(want), .pins(pins));
   task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <=
         {2'b11, we, adr, dat};
      do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] adr, logic [32:0] exp);
      exp_q.push_back(exp);
      wb(1'b0, adr, 32'h0);
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk)
      if ((wb_ack_o | wb_err_o) && !wb_we_i && exp_q.size() > 0)
         check("read", {wb_err_o, wb_err_o ? 32'h0 : wb_dat_o},
            exp_q.pop_front());
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         err_total++;
         close_out;
      end
   end
   initial begin
      logic [3:0] p;
      logic [2:0] f;
      logic a, b, c, d, e;
      void'($urandom(4));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // all sixteen pin sets, then random ones with the host keeping rules
      for (int i = 0; i < 20; i++) begin
         p = i < 16 ? i[3:0] : 4'($urandom);
         f = 3'($urandom);
         wb(1'b1, 8'h08, {29'h0, f});
         rd(8'h08, {30'h0, f});
         {keep, want, drive} <= {i >= 16, p, 1'b1};
         if (i % 5 == 4)
            chip_enable_in <= 1'b0;
         else
            src <= 4'h1 << (i % 5);
         repeat (LOW + 6) @(posedge clk);
         {src, chip_enable_in} <= 5'h01;
         repeat (8) @(posedge clk);
         drive <= 1'b0;
         {d, b, a} = {p[3], p[1:0]};
         c = p[2] | (i >= 16 && !p[1]);
         e = f[1:0] == 2'h0 | (f[1:0] == 2'h1 & !b) | (f[1:0] == 2'h2 & b);
         rd(8'h00, {30'h0, d, b, a});
         rd(8'h04, {27'h0, c, f[2] ? d : 1'b1, e, !b && !c,
            a && b && !c, a && c});
         $display("test %0d done", i);
      end
      wb(1'b1, 8'h00, $urandom);
      rd(8'h00, {30'h0, d, b, a});
      rd(8'h0c, {1'b1, 32'h0});
      close_out;
   end
endmodule // test_strap_sample_boot_select
bind strap_sample_boot_select strap_props #(
   .CHIP_EN_LOW_CYCLES(CHIP_EN_LOW_CYCLES)) props (.clk(clk),
   .reset(reset), .clk_en(clk_en), .chip_enable_in(chip_enable_in),
   .slow_wdt_reset(slow_wdt_reset), .brownout_reset(brownout_reset),
   .super_wdt_reset(super_wdt_reset), .xtal_glitch_reset(xtal_glitch_reset),
   .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b),
   .strap_pin_c(strap_pin_c), .strap_pin_d(strap_pin_d),
   .strap_pin_c_pullup(strap_pin_c_pullup), .strap_duty(strap_duty),
   .flash_boot(flash_boot), .download_boot(download_boot),
   .invalid_strap(invalid_strap), .system_reset_out(system_reset_out));
